//--- logic/acsr_map.vh
`ifndef ACSR_MAP_VH
`define ACSR_MAP_VH

// register offsets on the control port
`define ACSR_OFS_SRC_PLL        8'h34
`define ACSR_OFS_RATIO_HI       8'h35
`define ACSR_OFS_RATIO_LO       8'h36

// reset values
`define ACSR_RST_SRC_PLL        8'h40
`define ACSR_RST_RATIO_HI       8'h00
`define ACSR_RST_RATIO_LO       8'h00

// clock_source_pll_config fields
`define ACSR_BIT_PLL_OFF        7
`define ACSR_BIT_FRAC_PERMIT    6
`define ACSR_SRC_SEL_HI         3
`define ACSR_SRC_SEL_LO         1
`define ACSR_BIT_RATIO_EDGE     0
`define ACSR_SRC_PLL_WMASK      8'hCF

// controller_clock_ratio_high fields
`define ACSR_MIC_RATE_HI        7
`define ACSR_MIC_RATE_LO        6
`define ACSR_RATIO_UP_HI        5

// input clock source codes
`define ACSR_SRC_PRI_BCLK       3'h0
`define ACSR_SRC_REF_PRI_FS     3'h1
`define ACSR_SRC_SEC_BCLK       3'h2
`define ACSR_SRC_REF_SEC_FS     3'h3
`define ACSR_SRC_REF_FIXED      3'h4
`define ACSR_SRC_INT_OSC        3'h5

// ratio field
`define ACSR_RATIO_W            14
`define ACSR_RATIO_MAX          14'h3FFF
`define ACSR_RATIO_AUTO         14'h0000

// system clock and mic bitstream clock rates, in Hz
`define ACSR_CLK_HZ             64'd50000000
`define ACSR_MIC_48K_0          32'd3072000
`define ACSR_MIC_48K_1          32'd1536000
`define ACSR_MIC_48K_2          32'd768000
`define ACSR_MIC_48K_3          32'd6144000
`define ACSR_MIC_44K_0          32'd2822400
`define ACSR_MIC_44K_1          32'd1411200
`define ACSR_MIC_44K_2          32'd705600
`define ACSR_MIC_44K_3          32'd5644800

`endif

//--- logic/acsr_ratio_detect.v
`timescale 1ns/1ps
`include "acsr_map.vh"

// counts clock-source edges between two frame sync rising edges
module acsr_ratio_detect (
	// clock and reset
	input  wire                      clk_in,
	input  wire                      rstn_in,
	// sampled clock source and frame sync
	input  wire                      src_level_in,
	input  wire                      falling_in,
	input  wire                      fsync_in,
	input  wire                      enable_in,
	// result
	output reg  [`ACSR_RATIO_W-1:0]  ratio_out,
	output reg                       valid_out
);

	reg                      src_prev_q;
	reg                      fs_prev_q;
	reg  [`ACSR_RATIO_W-1:0] count_q;
	wire                     src_edge;
	wire                     fs_rise;

	// chosen edge of the source is the counting event
	assign src_edge = falling_in ? (src_prev_q & ~src_level_in) : (~src_prev_q & src_level_in);
	assign fs_rise  = ~fs_prev_q & fsync_in;

	// count saturates, yet a source edge in the frame sync cycle wraps a saturated count into a false ratio of zero
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			src_prev_q <= 1'b0;
			fs_prev_q  <= 1'b0;
			count_q    <= {`ACSR_RATIO_W{1'b0}};
			ratio_out  <= {`ACSR_RATIO_W{1'b0}};
			valid_out  <= 1'b0;
		end else begin
			src_prev_q <= src_level_in;
			fs_prev_q  <= fsync_in;
			if (!enable_in) begin
				count_q   <= {`ACSR_RATIO_W{1'b0}};
				valid_out <= 1'b0;
			end else if (fs_rise) begin
				ratio_out <= count_q + {{(`ACSR_RATIO_W-1){1'b0}}, src_edge};
				valid_out <= (count_q != {`ACSR_RATIO_W{1'b0}}) || src_edge;
				count_q   <= {`ACSR_RATIO_W{1'b0}};
			end else if (src_edge && count_q != `ACSR_RATIO_MAX) begin
				count_q <= count_q + 14'h0001;
			end
		end
	end

endmodule

//--- logic/acsr_clock_config.v
`timescale 1ns/1ps
`include "acsr_map.vh"

// Summary of operation
// [RULE1] pll off when set; else custom on, auto by load
// [RULE2] fractional pll only while permit bit set
// [RULE3] software writes zero to reserved bits five, four
// [RULE4] source codes zero to three pick clocks
// [RULE5] code four controller only, five custom only
// [RULE6] ratio edge: zero rising, one falling
// [RULE7] two-bit field sets mic bitstream clock rate
// [RULE8] fourteen-bit ratio split upper six, lower eight
// [RULE9] ratio zero means automatic ratio detection
// [RULE10] rate family picks 48k or 44.1k frequencies
// [RULE11] custom bit zero auto, one manual settings
module acsr_clock_config (
	// clock and reset
	input  wire                      clk_in,
	input  wire                      rstn_in,
	// register port from the control interface
	input  wire [7:0]                reg_addr_in,
	input  wire [7:0]                reg_wdata_in,
	input  wire                      reg_wr_in,
	input  wire                      reg_rd_in,
	output reg  [7:0]                reg_rdata_out,
	// mode bits held in neighbouring registers
	input  wire                      custom_clock_cfg_in,
	input  wire                      controller_mode_in,
	input  wire                      rate_family_select_in,
	input  wire                      dsp_load_high_in,
	// candidate clock sources, sampled levels
	input  wire                      primary_serial_port_bclk_in,
	input  wire                      primary_serial_port_fsync_in,
	input  wire                      secondary_serial_port_bclk_in,
	input  wire                      secondary_serial_port_fsync_in,
	input  wire                      controller_reference_clock_in,
	input  wire                      internal_osc_in,
	// clocking controls and status
	output reg                       pll_on_out,
	output reg                       pll_fractional_out,
	output reg                       source_clock_out,
	output reg                       source_valid_out,
	output reg  [`ACSR_RATIO_W-1:0]  ratio_out,
	output reg                       ratio_auto_out,
	output reg                       ratio_valid_out,
	output reg                       mic_bitstream_clock_out
);

	reg  [7:0]                src_pll_q;
	reg  [7:0]                ratio_hi_q;
	reg  [7:0]                ratio_lo_q;
	reg  [31:0]               nco_q;
	reg  [31:0]               nco_inc_d;
	reg                       src_level_d;
	reg                       fsync_d;
	reg                       src_ok_d;
	reg  [7:0]                rdata_d;
	wire [2:0]                src_sel;
	wire [1:0]                mic_rate;
	wire [`ACSR_RATIO_W-1:0]  prog_ratio;
	wire [`ACSR_RATIO_W-1:0]  meas_ratio;
	wire                      meas_valid;
	wire                      pll_on_d;

	// nco step for a target frequency: hz * 2^32 / system clock
	function [31:0] nco_step;
		input [31:0] hz;
		reg   [63:0] t;
		begin
			t        = {hz, 32'h0000_0000} / `ACSR_CLK_HZ;
			nco_step = t[31:0];
		end
	endfunction

	// mic bitstream frequency per rate code and rate family
	function [31:0] mic_hz;
		input [1:0] code;
		input       fam44;
		begin
			case (code)
				2'h0:    mic_hz = fam44 ? `ACSR_MIC_44K_0 : `ACSR_MIC_48K_0;
				2'h1:    mic_hz = fam44 ? `ACSR_MIC_44K_1 : `ACSR_MIC_48K_1;
				2'h2:    mic_hz = fam44 ? `ACSR_MIC_44K_2 : `ACSR_MIC_48K_2;
				default: mic_hz = fam44 ? `ACSR_MIC_44K_3 : `ACSR_MIC_48K_3;
			endcase
		end
	endfunction

	assign src_sel    = src_pll_q[`ACSR_SRC_SEL_HI:`ACSR_SRC_SEL_LO];
	assign mic_rate   = ratio_hi_q[`ACSR_MIC_RATE_HI:`ACSR_MIC_RATE_LO];
	assign prog_ratio = {ratio_hi_q[`ACSR_RATIO_UP_HI:0], ratio_lo_q}; // [RULE8]

	// register writes; reserved bits are masked so they always read zero
	// the split ratio has no shadow: between the two byte writes the mixed value is live,
	// so software must not change it while a programmed ratio is in use
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			src_pll_q  <= `ACSR_RST_SRC_PLL;
			ratio_hi_q <= `ACSR_RST_RATIO_HI;
			ratio_lo_q <= `ACSR_RST_RATIO_LO;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				`ACSR_OFS_SRC_PLL:  src_pll_q  <= reg_wdata_in & `ACSR_SRC_PLL_WMASK; // [RULE3]
				`ACSR_OFS_RATIO_HI: ratio_hi_q <= reg_wdata_in;
				`ACSR_OFS_RATIO_LO: ratio_lo_q <= reg_wdata_in;
				default: ;
			endcase
		end
	end

	// read mux; unmapped addresses answer zero
	always @* begin
		case (reg_addr_in)
			`ACSR_OFS_SRC_PLL:  rdata_d = src_pll_q;
			`ACSR_OFS_RATIO_HI: rdata_d = ratio_hi_q;
			`ACSR_OFS_RATIO_LO: rdata_d = ratio_lo_q;
			default:            rdata_d = 8'h00;
		endcase
	end

	// read data is held until the next read strobe
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			reg_rdata_out <= rdata_d;
		end
	end

	// pll: forced off, on in custom mode, load-driven in auto mode
	// the load request comes in as a level; deciding how much processing needs the pll
	// is left to the block that schedules the processing
	assign pll_on_d = ~src_pll_q[`ACSR_BIT_PLL_OFF] & (custom_clock_cfg_in | dsp_load_high_in); // [RULE1] [RULE11]

	// source mux; codes not legal in the present mode select nothing
	always @* begin
		src_level_d = 1'b0;
		fsync_d     = primary_serial_port_fsync_in;
		src_ok_d    = 1'b1;
		case (src_sel)
			`ACSR_SRC_PRI_BCLK: begin // [RULE4]
				src_level_d = primary_serial_port_bclk_in;
			end
			`ACSR_SRC_REF_PRI_FS: begin
				src_level_d = controller_reference_clock_in;
			end
			`ACSR_SRC_SEC_BCLK: begin
				src_level_d = secondary_serial_port_bclk_in;
				fsync_d     = secondary_serial_port_fsync_in;
			end
			`ACSR_SRC_REF_SEC_FS: begin
				src_level_d = controller_reference_clock_in;
				fsync_d     = secondary_serial_port_fsync_in;
			end
			`ACSR_SRC_REF_FIXED: begin // [RULE5]
				src_level_d = controller_reference_clock_in & controller_mode_in;
				src_ok_d    = controller_mode_in;
			end
			`ACSR_SRC_INT_OSC: begin // [RULE5] [RULE11]
				src_level_d = internal_osc_in & custom_clock_cfg_in;
				src_ok_d    = custom_clock_cfg_in;
			end
			default: begin // reserved codes: no clock rather than a guess
				src_ok_d    = 1'b0;
			end
		endcase
	end

	// ratio measurement on the selected source and its frame sync
	// the source is sampled by the system clock, so it must stay below half of it;
	// a faster source aliases and the measured ratio comes out too small
	acsr_ratio_detect u_detect (
		.clk_in       (clk_in),
		.rstn_in      (rstn_in),
		.src_level_in (src_level_d),
		.falling_in   (src_pll_q[`ACSR_BIT_RATIO_EDGE]), // [RULE6]
		.fsync_in     (fsync_d),
		.enable_in    (src_ok_d),
		.ratio_out    (meas_ratio),
		.valid_out    (meas_valid)
	);

	// mic bitstream clock step, family picks which of the pair applies
	always @* begin
		nco_inc_d = nco_step(mic_hz(mic_rate, rate_family_select_in)); // [RULE7] [RULE10]
	end

	// phase accumulator; its top bit is the bitstream clock, jitter is one system clock
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			nco_q <= 32'h0000_0000;
		end else begin
			nco_q <= nco_q + nco_inc_d;
		end
	end

	// registered outputs
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pll_on_out              <= 1'b0;
			pll_fractional_out      <= 1'b0;
			source_clock_out        <= 1'b0;
			source_valid_out        <= 1'b0;
			ratio_out               <= {`ACSR_RATIO_W{1'b0}};
			ratio_auto_out          <= 1'b1;
			ratio_valid_out         <= 1'b0;
			mic_bitstream_clock_out <= 1'b0;
		end else begin
			pll_on_out              <= pll_on_d;
			pll_fractional_out      <= pll_on_d & src_pll_q[`ACSR_BIT_FRAC_PERMIT]; // [RULE2]
			source_clock_out        <= src_level_d;
			source_valid_out        <= src_ok_d;
			mic_bitstream_clock_out <= nco_q[31];
			if (prog_ratio == `ACSR_RATIO_AUTO) begin // [RULE9]
				ratio_out       <= meas_ratio;
				ratio_auto_out  <= 1'b1;
				ratio_valid_out <= meas_valid;
			end else begin // [RULE8]
				ratio_out       <= prog_ratio;
				ratio_auto_out  <= 1'b0;
				ratio_valid_out <= 1'b1;
			end
		end
	end

endmodule

//--- verif/acsr_clock_config_checker.sv
`timescale 1ns/1ps
`include "acsr_map.vh"

module acsr_chk (
	// clock, reset and register port
	input wire                      clk_in,
	input wire                      rstn_in,
	input wire [7:0]                reg_addr_in,
	input wire [7:0]                reg_wdata_in,
	input wire                      reg_wr_in,
	input wire                      reg_rd_in,
	input wire [7:0]                reg_rdata_out,
	// mode input and clocking outputs
	input wire                      controller_mode_in,
	input wire                      pll_on_out,
	input wire                      pll_fractional_out,
	input wire                      source_valid_out,
	input wire [`ACSR_RATIO_W-1:0]  ratio_out,
	input wire                      ratio_auto_out,
	input wire                      ratio_valid_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	// write strobes for the clock_source_pll_config and ratio low registers; a second write right after would hide the first
	wire w_src = reg_wr_in && reg_addr_in == `ACSR_OFS_SRC_PLL;
	wire w_lo  = reg_wr_in && reg_addr_in == `ACSR_OFS_RATIO_LO;

	a_pll_off_write: assert property ((w_src && reg_wdata_in[7]) ##1 !w_src |=> !pll_on_out)
		else $error("pll on after off write");
	a_frac_clear: assert property ((w_src && !reg_wdata_in[6]) ##1 !w_src |=> !pll_fractional_out)
		else $error("fractional kept without permit");
	a_frac_needs_pll: assert property (pll_fractional_out |-> pll_on_out)
		else $error("fractional with pll off");
	a_rsvd_read_zero: assert property (reg_rd_in && reg_addr_in == `ACSR_OFS_SRC_PLL |=> reg_rdata_out[5:4] == 2'b00)
		else $error("reserved bits read nonzero");
	a_src_reserved: assert property ((w_src && reg_wdata_in[3:2] == 2'b11) ##1 !w_src |=> !source_valid_out)
		else $error("reserved source accepted");
	a_src_fixed_ref: assert property ((w_src && reg_wdata_in[3:1] == 3'h4 && !controller_mode_in)
		##1 (!w_src && !controller_mode_in) |=> !source_valid_out) else $error("fixed ref outside controller");
	a_ratio_low: assert property ((w_lo && reg_wdata_in != 8'h00) ##1 !reg_wr_in
		|=> !ratio_auto_out && ratio_out[7:0] == $past(reg_wdata_in, 2)) else $error("ratio low byte wrong");
	a_prog_valid: assert property (!ratio_auto_out |-> ratio_valid_out)
		else $error("programmed ratio not valid");
	a_rdata_hold: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
		else $error("read data moved without read");
endmodule

bind acsr_clock_config acsr_chk u_chk (.clk_in, .rstn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
	.reg_rdata_out, .controller_mode_in, .pll_on_out, .pll_fractional_out, .source_valid_out, .ratio_out,
	.ratio_auto_out, .ratio_valid_out);

//--- verif/testbench.sv
`timescale 1ns/1ps
`include "acsr_map.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module testbench;
	reg         clk_in = 1'b0;
	reg         rstn_in = 1'b0;
	reg  [7:0]  addr = 8'h00, wdata = 8'h00;
	reg         wr = 1'b0, rd = 1'b0, custom = 1'b0, ctrl = 1'b0, fam = 1'b0, load = 1'b0;
	reg         pb = 1'b0, pf = 1'b0, sb = 1'b0, sf = 1'b0, refc = 1'b0, osc = 1'b0;
	wire [7:0]  rdata;
	wire        pll_on, frac, src, src_ok, r_auto, r_ok, mic;
	wire [13:0] ratio;
	integer     err_count = 0, n_compared = 0;

	acsr_clock_config uut (
		.clk_in(clk_in), .rstn_in(rstn_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .custom_clock_cfg_in(custom),
		.controller_mode_in(ctrl), .rate_family_select_in(fam), .dsp_load_high_in(load),
		.primary_serial_port_bclk_in(pb), .primary_serial_port_fsync_in(pf),
		.secondary_serial_port_bclk_in(sb), .secondary_serial_port_fsync_in(sf),
		.controller_reference_clock_in(refc), .internal_osc_in(osc), .pll_on_out(pll_on),
		.pll_fractional_out(frac), .source_clock_out(src), .source_valid_out(src_ok), .ratio_out(ratio),
		.ratio_auto_out(r_auto), .ratio_valid_out(r_ok), .mic_bitstream_clock_out(mic));

	// 50 MHz clock
	initial forever #10 clk_in = ~clk_in;

	// one write, then one more cycle so the outputs have followed the register
	task wreg(input [7:0] a, input [7:0] d);
		begin
			@(negedge clk_in);
			addr = a;
			wdata = d;
			wr = 1'b1;
			@(negedge clk_in);
			wr = 1'b0;
			@(negedge clk_in);
		end
	endtask

	// read data is loaded by the strobe edge and checked just after it
	task rchk(input [7:0] a, input [7:0] e);
		begin
			@(negedge clk_in);
			addr = a;
			rd = 1'b1;
			@(negedge clk_in);
			rd = 1'b0;
			`CHK(rdata, e)
		end
	endtask

	task t_reset;
		begin
			rchk(`ACSR_OFS_SRC_PLL, `ACSR_RST_SRC_PLL);
			rchk(`ACSR_OFS_RATIO_HI, 8'h00);
			rchk(`ACSR_OFS_RATIO_LO, 8'h00);
			rchk(8'h37, 8'h00);
			`CHK(r_auto, 1'b1)
		end
	endtask

	task t_pll;
		begin
			custom = 1'b1;
			wreg(`ACSR_OFS_SRC_PLL, 8'h00);
			`CHK({pll_on, frac}, 2'b10)
			wreg(`ACSR_OFS_SRC_PLL, 8'h40);
			`CHK({pll_on, frac}, 2'b11)
			wreg(`ACSR_OFS_SRC_PLL, 8'hFF);
			`CHK({pll_on, frac}, 2'b00)
			rchk(`ACSR_OFS_SRC_PLL, 8'hCF);
			custom = 1'b0;
			wreg(`ACSR_OFS_SRC_PLL, 8'h40);
			`CHK(pll_on, 1'b0)
			load = 1'b1;
			repeat (2) @(negedge clk_in);
			`CHK(pll_on, 1'b1)
		end
	endtask

	// every source code in a restricted mode and in controller plus custom mode
	task t_src;
		integer m, c;
		reg ok;
		reg [7:0] lvl;
		begin
			lvl = 8'h25;
			pb = 1'b1;
			sb = 1'b1;
			osc = 1'b1;
			for (m = 0; m < 2; m++) begin
				custom = m[0];
				ctrl = m[0];
				for (c = 0; c < 8; c++) begin
					wreg(`ACSR_OFS_SRC_PLL, {4'h4, c[2:0], 1'b0});
					@(negedge clk_in);
					ok = m ? c < 6 : c < 4;
					`CHK({src_ok, src}, {ok, ok & lvl[c]})
				end
			end
		end
	endtask

	task t_ratio;
		begin
			wreg(`ACSR_OFS_RATIO_HI, 8'hFF);
			wreg(`ACSR_OFS_RATIO_LO, 8'hFF);
			`CHK({r_auto, r_ok, ratio}, {2'b01, `ACSR_RATIO_MAX})
			rchk(`ACSR_OFS_RATIO_HI, 8'hFF);
			wreg(`ACSR_OFS_RATIO_HI, 8'h00);
			wreg(`ACSR_OFS_RATIO_LO, 8'h01);
			`CHK(ratio, 14'h0001)
		end
	endtask

	// frame sync every 32 cycles; the source toggles only up to cycle 48, so the
	// last measured frame holds a different count of rising and falling edges
	task t_auto(input e, input sec);
		integer i;
		reg     lvl;
		begin
			wreg(`ACSR_OFS_RATIO_LO, 8'h00);
			wreg(`ACSR_OFS_SRC_PLL, {5'h08, sec, 1'b0, e});
			for (i = 0; i < 96; i++) begin
				@(negedge clk_in);
				lvl = (i >= 48) | (sec ? i[0] : i[1]);
				if (sec) begin
					sb = lvl;
					sf = (i % 32) < 4;
				end else begin
					pb = lvl;
					pf = (i % 32) < 4;
				end
			end
			repeat (3) @(negedge clk_in);
			`CHK({r_auto, r_ok, ratio}, {2'b11, sec ? 14'h0008 : (e ? 14'h0003 : 14'h0004)})
		end
	endtask

	// rising edges over 20 us; the accumulator allows one edge of slack
	task t_mic(input [1:0] c, input f, input integer n);
		integer i, k;
		reg p;
		begin
			fam = f;
			wreg(`ACSR_OFS_RATIO_HI, {c, 6'h00});
			k = 0;
			p = mic;
			for (i = 0; i < 1000; i++) begin
				@(negedge clk_in);
				k += (mic && !p);
				p = mic;
			end
			`CHK(k >= n - 1 && k <= n + 1, 1'b1)
		end
	endtask

	task wrap_up;
		begin
			$display("compared %0d mismatches %0d", n_compared, err_count);
			if (err_count == 0 && n_compared > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask

	// main sequence after eight cycles of reset
	initial begin
		repeat (8) @(negedge clk_in);
		rstn_in = 1'b1;
		t_reset;
		t_pll;
		t_src;
		t_ratio;
		t_auto(1'b0, 1'b0);
		t_auto(1'b1, 1'b0);
		t_auto(1'b0, 1'b1);
		t_mic(2'd0, 1'b0, 61);
		t_mic(2'd3, 1'b1, 113);
		t_mic(2'd2, 1'b0, 15);
		t_mic(2'd1, 1'b1, 28);
		wrap_up;
	end

	// cuts a hang short
	initial begin
		repeat (20000) @(posedge clk_in);
		err_count++;
		wrap_up;
	end
endmodule
